// [core/sas_pkg.sv]
// Shared constants and types for the converter sequencer
package sas_pkg;

    // ------------------------------------------------------------
    // Conversion lengths in conversion-clock cycles
    // ------------------------------------------------------------
    localparam logic [5:0] SAS_CYC_8B_PLAIN = 6'd49;
    localparam logic [5:0] SAS_CYC_10B_PLAIN = 6'd59;
    localparam logic [5:0] SAS_CYC_8B_SH = 6'd28;
    localparam logic [5:0] SAS_CYC_10B_SH = 6'd33;
    localparam logic [5:0] SAS_TRIAL_LEN = 6'd3;
    localparam logic [3:0] SAS_BITS_8 = 4'd8;
    localparam logic [3:0] SAS_BITS_10 = 4'd10;

    // ------------------------------------------------------------
    // Divider selects and terminal counts
    // ------------------------------------------------------------
    localparam logic [1:0] SAS_DIV_1 = 2'h0;
    localparam logic [1:0] SAS_DIV_2 = 2'h1;
    localparam logic [1:0] SAS_DIV_4 = 2'h2;
    localparam logic [1:0] SAS_DIV_1_LIMIT = 2'h0;
    localparam logic [1:0] SAS_DIV_2_LIMIT = 2'h1;
    localparam logic [1:0] SAS_DIV_4_LIMIT = 2'h3;

    // ------------------------------------------------------------
    // Mode field, extended-input field, mux groups
    // ------------------------------------------------------------
    localparam logic [2:0] SAS_MODE_ONESHOT = 3'h0;
    localparam logic [2:0] SAS_MODE_REPEAT = 3'h1;
    localparam logic [2:0] SAS_MODE_SWEEP = 3'h2;
    localparam logic [2:0] SAS_MODE_RSWEEP0 = 3'h3;
    localparam logic [2:0] SAS_MODE_RSWEEP1 = 3'h4;
    localparam logic [1:0] SAS_EXT_NONE = 2'h0;
    localparam logic [1:0] SAS_EXT_IN0 = 2'h1;
    localparam logic [1:0] SAS_EXT_IN1 = 2'h2;
    localparam logic [1:0] SAS_EXT_OPAMP = 2'h3;
    localparam logic [1:0] SAS_GRP_PRIMARY = 2'h0;
    localparam logic [1:0] SAS_GRP_ALTERNATE = 2'h1;
    localparam logic [1:0] SAS_GRP_EXT0 = 2'h2;
    localparam logic [1:0] SAS_GRP_EXT1 = 2'h3;

    // ------------------------------------------------------------
    // Result storage and reset values
    // ------------------------------------------------------------
    localparam int SAS_RESULT_REGS = 8;
    localparam logic [2:0] SAS_EXT0_REG = 3'h0;
    localparam logic [2:0] SAS_EXT1_REG = 3'h1;
    localparam logic [15:0] SAS_RESULT_RESET = 16'h0000;

    typedef enum logic [1:0] {
        SAS_ST_IDLE,
        SAS_ST_CONV,
        SAS_ST_WRITE
    } sas_state_t;

endpackage : sas_pkg

// [core/sas_mem_if.sv]
// Connection between sequencer and result memory
`timescale 1ns/1ps
interface sas_mem_if;
    logic wr_en;
    logic [2:0] wr_addr;
    logic [15:0] wr_data;
    logic [3:0] rd_addr;
    logic [7:0] rd_data;

    modport seq (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : sas_mem_if

// [core/sas_result_mem.sv]
// Per-pin result registers with registered byte read
`timescale 1ns/1ps
module sas_result_mem
    import sas_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    sas_mem_if.mem mif
);
    logic [15:0] word_q [SAS_RESULT_REGS];
    logic [7:0] rd_q;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < SAS_RESULT_REGS; i++) begin
                word_q[i] <= SAS_RESULT_RESET;
            end
        end else if (mif.wr_en) begin
            word_q[mif.wr_addr] <= mif.wr_data;
        end
    end

    // ------------------------------------------------------------
    // Even byte low eight bits, odd byte upper bits
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_q <= 8'h00;
        end else if (mif.rd_addr[0]) begin
            rd_q <= word_q[mif.rd_addr[3:1]][15:8]; // [R2]
        end else begin
            rd_q <= word_q[mif.rd_addr[3:1]][7:0]; // [R2] [R3]
        end
    end

    assign mif.rd_data = rd_q;

endmodule : sas_result_mem

// [core/sas_sequencer.sv]
// Successive-approximation converter sequencer, top level
// Notes on behaviour
// [R1] Ten-bit successive approximation core, result width 8 or 10 bits selectable.
// [R2] Ten-bit result: low eight bits at even byte, top two at odd.
// [R3] Eight-bit result sits at the even byte of the pin's register.
// [R4] Reference connect bit gates ladder current; set it before any conversion.
// [R5] Control must not change mid-conversion; result is then undefined.
// [R6] Software trigger: conversion starts when start flag rises 0 to 1.
// [R7] External trigger: each falling trigger edge with flag set (re)starts conversion.
// [R8] Plain conversion: 49 cycles at 8 bits, 59 at 10 bits.
// [R9] With sample-and-hold: 28 cycles at 8 bits, 33 at 10 bits.
// [R10] Conversion clock is source clock divided by 1, 2 or 4.
// [R11] Software keeps conversion clock within 250 kHz/1 MHz and 10 MHz.
// [R12] Five modes chosen by mode field; only one-shot and repeat run.
// [R13] One-shot converts the selected pin once, then requests an interrupt.
// [R14] One-shot end clears start flag unless externally triggered; writing 0 stops.
// [R15] Repeat converts continuously, no interrupt, stops when flag written 0.
// [R16] Each result goes to the register of the pin just converted; op-amp mode writes to the chan_sel_in register.
// [R17] Inputs: eight primary, two extended, eight alternate replacing the primary.
// [R18] Extended field: 00 unused, 01 input 0, 10 input 1, 11 op-amp.
// [R19] Sample-and-hold enable bit chosen before any conversion starts.
// [R20] Interrupt pulses one cycle after the result register is updated.
`timescale 1ns/1ps
module sas_sequencer
    import sas_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic start_wr_in,
    input wire logic start_wdata_in,
    input wire logic [2:0] mode_in,
    input wire logic ext_trig_sel_in,
    input wire logic external_trigger_pin_in,
    input wire logic reference_connect_bit_in,
    input wire logic res10_in,
    input wire logic sample_hold_en_in,
    input wire logic [1:0] clk_div_sel_in,
    input wire logic [2:0] chan_sel_in,
    input wire logic alt_group_sel_in,
    input wire logic extended_input_select_lo_in,
    input wire logic extended_input_select_hi_in,
    input wire logic comp_in,
    input wire logic [3:0] rd_byte_addr_in,
    output logic [7:0] rd_data_out,
    output logic start_flag_out,
    output logic busy_out,
    output logic eoc_irq_out,
    output logic ladder_enable_out,
    output logic sample_out,
    output logic [9:0] sar_code_out,
    output logic [1:0] mux_group_out,
    output logic [2:0] mux_chan_out,
    output logic opamp_mode_out
);
    import sas_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [5:0] conv_cycles(input logic r10, input logic sh);
        if (sh) begin
            conv_cycles = r10 ? SAS_CYC_10B_SH : SAS_CYC_8B_SH; // [R9]
        end else begin
            conv_cycles = r10 ? SAS_CYC_10B_PLAIN : SAS_CYC_8B_PLAIN; // [R8]
        end
    endfunction : conv_cycles

    function automatic logic [3:0] num_bits(input logic r10);
        num_bits = r10 ? SAS_BITS_10 : SAS_BITS_8; // [R1]
    endfunction : num_bits

    function automatic logic [1:0] div_limit(input logic [1:0] sel);
        case (sel)
            SAS_DIV_2: div_limit = SAS_DIV_2_LIMIT;
            SAS_DIV_4: div_limit = SAS_DIV_4_LIMIT;
            default: div_limit = SAS_DIV_1_LIMIT;
        endcase
    endfunction : div_limit

    sas_mem_if mif ();

    sas_state_t state_q;
    logic start_flag_q, flag_prev_q;
    logic trig_meta_q, trig_sync_q, trig_prev_q;
    logic comp_meta_q, comp_sync_q;
    logic [1:0] div_cnt_q;
    logic [5:0] cyc_q;
    logic [1:0] sub_q;
    logic [3:0] bit_q;
    logic [9:0] sar_q;
    logic cfg_r10_q, cfg_sh_q, cfg_oneshot_q, cfg_ext_q;
    logic [1:0] cfg_div_q;
    logic [2:0] cfg_addr_q;
    logic mem_wr_q, wr_irq_q, irq_q;
    logic [2:0] mem_addr_q;
    logic [15:0] mem_data_q;
    logic busy_q, sample_q, ladder_q, opamp_q;
    logic [1:0] group_q;
    logic [2:0] chan_q;
    logic [1:0] ext_field;
    logic mode_ok, trig_fall, sw_start, ext_start, start_evt, tick;
    logic [5:0] total, trial_begin;

    assign ext_field = {extended_input_select_hi_in, extended_input_select_lo_in};
    assign mode_ok = (mode_in == SAS_MODE_ONESHOT) || (mode_in == SAS_MODE_REPEAT); // [R12]
    assign trig_fall = trig_prev_q && !trig_sync_q;
    assign sw_start = !ext_trig_sel_in && start_flag_q && !flag_prev_q; // [R6]
    assign ext_start = ext_trig_sel_in && start_flag_q && trig_fall; // [R7]
    assign start_evt = mode_ok && (sw_start || ext_start);
    assign tick = (div_cnt_q == div_limit(cfg_div_q)); // [R10]
    assign total = conv_cycles(cfg_r10_q, cfg_sh_q);
    assign trial_begin = total - 6'(SAS_TRIAL_LEN * 6'(num_bits(cfg_r10_q)));

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            trig_meta_q <= 1'b1;
            trig_sync_q <= 1'b1;
            trig_prev_q <= 1'b1;
            comp_meta_q <= 1'b0;
            comp_sync_q <= 1'b0;
        end else begin
            trig_meta_q <= external_trigger_pin_in;
            trig_sync_q <= trig_meta_q;
            trig_prev_q <= trig_sync_q;
            comp_meta_q <= comp_in;
            comp_sync_q <= comp_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Start flag: software write beats hardware clear
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            start_flag_q <= 1'b0;
            flag_prev_q <= 1'b0;
        end else begin
            flag_prev_q <= start_flag_q;
            if (start_wr_in) begin
                start_flag_q <= start_wdata_in; // [R14] [R15]
            end else if (state_q == SAS_ST_WRITE && cfg_oneshot_q && !cfg_ext_q) begin
                start_flag_q <= 1'b0; // [R14]
            end
        end
    end

    // ------------------------------------------------------------
    // Conversion clock divider
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            div_cnt_q <= 2'h0;
        end else if (start_evt || state_q != SAS_ST_CONV || tick) begin
            div_cnt_q <= 2'h0; // [R10]
        end else begin
            div_cnt_q <= div_cnt_q + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Configuration captured at start
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_r10_q <= 1'b0;
            cfg_sh_q <= 1'b0;
            cfg_oneshot_q <= 1'b0;
            cfg_ext_q <= 1'b0;
            cfg_div_q <= SAS_DIV_1;
            cfg_addr_q <= 3'h0;
            group_q <= SAS_GRP_PRIMARY;
            chan_q <= 3'h0;
            opamp_q <= 1'b0;
        end else if (start_evt) begin
            cfg_r10_q <= res10_in; // [R1]
            cfg_sh_q <= sample_hold_en_in; // [R19]
            cfg_oneshot_q <= (mode_in == SAS_MODE_ONESHOT);
            cfg_ext_q <= ext_trig_sel_in;
            cfg_div_q <= clk_div_sel_in;
            chan_q <= chan_sel_in;
            opamp_q <= (ext_field == SAS_EXT_OPAMP); // [R18]
            case (ext_field)
                SAS_EXT_IN0: begin
                    group_q <= SAS_GRP_EXT0; // [R18]
                    cfg_addr_q <= SAS_EXT0_REG; // [R16]
                end
                SAS_EXT_IN1: begin
                    group_q <= SAS_GRP_EXT1;
                    cfg_addr_q <= SAS_EXT1_REG;
                end
                SAS_EXT_OPAMP: begin
                    group_q <= SAS_GRP_EXT1;
                    cfg_addr_q <= chan_sel_in;
                end
                default: begin
                    group_q <= alt_group_sel_in ? SAS_GRP_ALTERNATE : SAS_GRP_PRIMARY; // [R17]
                    cfg_addr_q <= chan_sel_in; // [R16]
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sequencer and bit trials
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= SAS_ST_IDLE;
            cyc_q <= 6'h00;
            sub_q <= 2'h0;
            bit_q <= 4'h0;
            sar_q <= 10'h000;
        end else if (!start_flag_q) begin
            state_q <= SAS_ST_IDLE; // [R14] [R15]
        end else if (start_evt) begin
            state_q <= SAS_ST_CONV; // [R6] [R7]
            cyc_q <= 6'h00;
            sub_q <= 2'h0;
            bit_q <= SAS_BITS_10 - 4'h1; // [R1]
            sar_q <= 10'h000;
        end else begin
            case (state_q)
                SAS_ST_CONV: begin
                    if (tick) begin
                        if (cyc_q == total - 6'h01) begin
                            state_q <= SAS_ST_WRITE; // [R8] [R9]
                        end else begin
                            cyc_q <= cyc_q + 6'h01;
                        end
                        if (cyc_q >= trial_begin) begin
                            sub_q <= (sub_q == 2'h2) ? 2'h0 : sub_q + 2'h1;
                            if (sub_q == 2'h0) begin
                                sar_q[bit_q] <= 1'b1; // [R1]
                            end else if (sub_q == 2'h2) begin
                                if (!comp_sync_q) begin
                                    sar_q[bit_q] <= 1'b0;
                                end
                                bit_q <= bit_q - 4'h1;
                            end
                        end
                    end
                end
                SAS_ST_WRITE: begin
                    if (cfg_oneshot_q) begin
                        state_q <= SAS_ST_IDLE; // [R13]
                    end else begin
                        state_q <= SAS_ST_CONV; // [R15]
                        cyc_q <= 6'h00;
                        sub_q <= 2'h0;
                        bit_q <= SAS_BITS_10 - 4'h1;
                        sar_q <= 10'h000;
                    end
                end
                default: state_q <= SAS_ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Result write and end-of-conversion request
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            mem_wr_q <= 1'b0;
            wr_irq_q <= 1'b0;
            mem_addr_q <= 3'h0;
            mem_data_q <= SAS_RESULT_RESET;
            irq_q <= 1'b0;
        end else begin
            mem_wr_q <= (state_q == SAS_ST_WRITE);
            wr_irq_q <= (state_q == SAS_ST_WRITE) && cfg_oneshot_q; // [R13] [R15]
            mem_addr_q <= cfg_addr_q; // [R16]
            mem_data_q <= cfg_r10_q ? {6'h00, sar_q} : {8'h00, sar_q[9:2]}; // [R2] [R3]
            irq_q <= mem_wr_q && wr_irq_q; // [R20]
        end
    end

    // ------------------------------------------------------------
    // Status and analog-side outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_q <= 1'b0;
            sample_q <= 1'b0;
            ladder_q <= 1'b0;
        end else begin
            busy_q <= (state_q != SAS_ST_IDLE);
            sample_q <= (state_q == SAS_ST_CONV) && (cyc_q < trial_begin) && cfg_sh_q; // [R19]
            ladder_q <= reference_connect_bit_in; // [R4]
        end
    end

    assign mif.wr_en = mem_wr_q;
    assign mif.wr_addr = mem_addr_q;
    assign mif.wr_data = mem_data_q;
    assign mif.rd_addr = rd_byte_addr_in;

    sas_result_mem u_mem (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .mif(mif.mem)
    );

    assign rd_data_out = mif.rd_data;
    assign start_flag_out = start_flag_q;
    assign busy_out = busy_q;
    assign eoc_irq_out = irq_q;
    assign ladder_enable_out = ladder_q;
    assign sample_out = sample_q;
    assign sar_code_out = sar_q;
    assign mux_group_out = group_q;
    assign mux_chan_out = chan_q;
    assign opamp_mode_out = opamp_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [5:0] ticks_seen_q;
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ticks_seen_q <= 6'h00;
        end else if (start_evt || state_q != SAS_ST_CONV) begin
            ticks_seen_q <= 6'h00;
        end else if (tick) begin
            ticks_seen_q <= ticks_seen_q + 6'h01;
        end
    end

    sequence s_div4_quiet;
        (cfg_div_q == SAS_DIV_4 && state_q == SAS_ST_CONV && !start_evt && start_flag_q) [*3];
    endsequence

    AST_IRQ_AFTER_WRITE: assert property (@(posedge mclk_in) disable iff (rst_in) // [R20]
        (state_q == SAS_ST_WRITE && cfg_oneshot_q) |=> mem_wr_q ##1 irq_q ##1 !irq_q)
        else $error("interrupt not one cycle after result update");
    AST_NO_IRQ_REPEAT: assert property (@(posedge mclk_in) disable iff (rst_in) // [R15]
        irq_q |-> $past(wr_irq_q, 1) && $past(mem_wr_q, 1))
        else $error("interrupt without one-shot result write");
    AST_FLAG_CLEAR: assert property (@(posedge mclk_in) disable iff (rst_in) // [R14]
        (state_q == SAS_ST_WRITE && cfg_oneshot_q && !cfg_ext_q && !start_wr_in) |=> !start_flag_q)
        else $error("start flag not cleared after one-shot");
    AST_SW_START: assert property (@(posedge mclk_in) disable iff (rst_in) // [R6]
        (mode_ok && !ext_trig_sel_in && start_flag_q && !flag_prev_q) |=> state_q == SAS_ST_CONV && cyc_q == 6'h00)
        else $error("software start not taken");
    AST_EXT_RETRIGGER: assert property (@(posedge mclk_in) disable iff (rst_in) // [R7]
        (mode_ok && ext_trig_sel_in && start_flag_q && trig_prev_q && !trig_sync_q)
        |=> state_q == SAS_ST_CONV && ticks_seen_q == 6'h00)
        else $error("trigger edge did not restart conversion");
    AST_LEN_PLAIN: assert property (@(posedge mclk_in) disable iff (rst_in) // [R8]
        (state_q == SAS_ST_WRITE && !cfg_sh_q)
        |-> ticks_seen_q == (cfg_r10_q ? SAS_CYC_10B_PLAIN : SAS_CYC_8B_PLAIN))
        else $error("plain conversion length wrong");
    AST_LEN_SH: assert property (@(posedge mclk_in) disable iff (rst_in) // [R9]
        (state_q == SAS_ST_WRITE && cfg_sh_q)
        |-> ticks_seen_q == (cfg_r10_q ? SAS_CYC_10B_SH : SAS_CYC_8B_SH))
        else $error("sample-and-hold conversion length wrong");
    AST_DIV4: assert property (@(posedge mclk_in) disable iff (rst_in) // [R10]
        (tick && state_q == SAS_ST_CONV && cfg_div_q == SAS_DIV_4) ##1 s_div4_quiet |=> tick)
        else $error("divide-by-four spacing wrong");
    AST_BYTE_LAYOUT: assert property (@(posedge mclk_in) disable iff (rst_in) // [R2] [R3]
        mem_wr_q |-> (mem_data_q[15:10] == 6'h00) && ($past(cfg_r10_q, 1) || mem_data_q[9:8] == 2'h0))
        else $error("result byte layout wrong");
    AST_EXT0_REG: assert property (@(posedge mclk_in) disable iff (rst_in) // [R16] [R18]
        (start_evt && ext_field == SAS_EXT_IN0) |=> cfg_addr_q == SAS_EXT0_REG && mux_group_out == SAS_GRP_EXT0)
        else $error("extended input 0 routed wrongly");

endmodule : sas_sequencer

// [test/sas_analog_model.sv]
// Analog source model: input levels behind the multiplexer and the comparator
`timescale 1ns/1ps
module sas_analog_model (
    input wire logic [9:0] code_in,
    input wire logic [1:0] group_in,
    input wire logic [2:0] chan_in,
    input wire logic opamp_in,
    output logic comp_out
);
    logic [9:0] lvl [0:17];
    logic [4:0] idx;
    // Op-amp mode converts the second extended input
    assign idx = opamp_in ? 5'h11 : group_in[1] ? {4'h8, group_in[0]} : {1'b0, group_in[0], chan_in};
    assign comp_out = lvl[idx] >= code_in;
endmodule : sas_analog_model

// [test/tb_top.sv]
// Self-checking testbench for the converter sequencer
`timescale 1ns/1ps
module tb_top;
    import sas_pkg::*;
    typedef struct {logic [3:0] adr; logic [15:0] val; int n;} sas_exp_t;
    logic mclk_in = 0, rst_in = 1, start_wr_in = 0, start_wdata_in = 0, ext_trig_sel_in = 0, pin = 1;
    logic reference_connect_bit_in = 1, res10_in = 0, sample_hold_en_in = 0, alt_group_sel_in = 0, comp;
    logic extended_input_select_lo_in = 0, extended_input_select_hi_in = 0, opamp_mode_out, done = 0;
    logic [2:0] mode_in = 0, chan_sel_in = 0, mux_chan_out;
    logic [1:0] clk_div_sel_in = 1, mux_group_out;
    logic [3:0] rd_byte_addr_in = 0;
    logic [7:0] rd_data_out;
    logic [9:0] sar_code_out;
    logic start_flag_out, busy_out, eoc_irq_out, ladder_enable_out, sample_out;
    int n_errors = 0, cmp_count = 0, cyc = 0, t0 = 0, seed = 37, i, n;
    sas_exp_t exp_q[$];
    sas_exp_t e;
    always #12.5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) cyc <= cyc + 1;
    sas_sequencer i_sas_sequencer (.mclk_in, .rst_in, .start_wr_in, .start_wdata_in, .mode_in, .ext_trig_sel_in,
        .external_trigger_pin_in(pin), .reference_connect_bit_in, .res10_in, .sample_hold_en_in, .clk_div_sel_in,
        .chan_sel_in, .alt_group_sel_in, .extended_input_select_lo_in, .extended_input_select_hi_in, .comp_in(comp),
        .rd_byte_addr_in, .rd_data_out, .start_flag_out, .busy_out, .eoc_irq_out, .ladder_enable_out,
        .sample_out, .sar_code_out, .mux_group_out, .mux_chan_out, .opamp_mode_out);
    sas_analog_model i_model (.code_in(sar_code_out), .group_in(mux_group_out), .chan_in(mux_chan_out),
        .opamp_in(opamp_mode_out), .comp_out(comp));
    task chk(input logic [15:0] got, input logic [15:0] want);
        cmp_count++;
        if (got !== want) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
        end
    endtask : chk
    task summarize;
        $display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize
    task wr_flag(input logic v);
        @(negedge mclk_in);
        start_wr_in = 1;
        start_wdata_in = v;
        t0 = cyc;
        @(negedge mclk_in);
        start_wr_in = 0;
    endtask : wr_flag
    task run1(input logic [3:0] cfg, input logic x);
        logic [9:0] lv;
        logic [4:0] idx;
        logic [2:0] r;
        int nc;
        @(negedge mclk_in);
        res10_in = cfg[0];
        sample_hold_en_in = cfg[1];
        {extended_input_select_hi_in, extended_input_select_lo_in} = cfg[3:2];
        lv = 10'($random(seed));
        alt_group_sel_in = lv[0];
        chan_sel_in = lv[3:1];
        clk_div_sel_in = SAS_DIV_4;
        lv = 10'($random(seed));
        idx = (cfg[3:2] == 2'h1) ? 5'd16 : cfg[3] ? 5'd17 : {1'b0, alt_group_sel_in, chan_sel_in};
        r = (cfg[3:2] == 2'h1) ? SAS_EXT0_REG : (cfg[3:2] == 2'h2) ? SAS_EXT1_REG : chan_sel_in;
        i_model.lvl[idx] = lv;
        nc = (cfg[1] ? (cfg[0] ? 33 : 28) : (cfg[0] ? 59 : 49)) * 4;
        exp_q.push_back('{{r, 1'b0}, cfg[0] ? {6'h0, lv} : {8'h0, lv[9:2]}, nc});
        wr_flag(1);
        if (x) begin
            repeat (10) @(negedge mclk_in);
            chk({15'h0, busy_out}, 16'h0);
            @(negedge mclk_in) pin = 0;
            repeat (15) @(negedge mclk_in);
            pin = 1;
            repeat (15) @(negedge mclk_in);
            pin = 0;
            t0 = cyc;
        end else begin
            repeat (6) @(negedge mclk_in);
            chk({15'h0, opamp_mode_out}, {15'h0, cfg[3:2] == 2'h3});
            chk({14'h0, sample_out, busy_out}, {14'h0, cfg[1], 1'b1});
        end
        for (n = 0; n < 600 && !done; n++) @(negedge mclk_in);
        chk({15'h0, done}, 16'h1);
        done = 0;
        pin = 1;
        chk({15'h0, start_flag_out}, {15'h0, x});
        wr_flag(0);
    endtask : run1
    initial forever begin
        @(posedge mclk_in);
        #1;
        if (eoc_irq_out === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(16'h1, 16'h0);
            end else begin
                e = exp_q.pop_front();
                chk({15'h0, (cyc - t0 >= e.n) && (cyc - t0 <= e.n + 8)}, 16'h1);
                @(negedge mclk_in) rd_byte_addr_in = e.adr;
                @(negedge mclk_in) chk({8'h0, rd_data_out}, {8'h0, e.val[7:0]});
                rd_byte_addr_in = e.adr | 4'h1;
                @(negedge mclk_in) chk({8'h0, rd_data_out}, {8'h0, e.val[15:8]});
                done = 1;
            end
        end
    end
    initial begin
        repeat (30000) @(posedge mclk_in);
        n_errors++;
        summarize;
    end
    initial begin
        repeat (6) @(posedge mclk_in);
        @(negedge mclk_in) rst_in = 0;
        repeat (3) @(negedge mclk_in);
        chk({12'h0, busy_out, start_flag_out, eoc_irq_out, ladder_enable_out}, 16'h1);
        for (i = 0; i < 16; i++) run1(i[3:0], 1'b0);
        $display("test one-shot configurations done");
        for (i = 2; i < 5; i++) begin
            @(negedge mclk_in) mode_in = i[2:0];
            wr_flag(1);
            repeat (20) @(negedge mclk_in);
            chk({15'h0, busy_out}, 16'h0);
            wr_flag(0);
        end
        @(negedge mclk_in) mode_in = SAS_MODE_ONESHOT;
        wr_flag(1);
        repeat (30) @(posedge mclk_in);
        wr_flag(0);
        repeat (300) @(negedge mclk_in);
        chk({15'h0, busy_out}, 16'h0);
        @(negedge mclk_in) mode_in = SAS_MODE_REPEAT;
        wr_flag(1);
        repeat (400) @(negedge mclk_in);
        chk({14'h0, busy_out, start_flag_out}, 16'h3);
        wr_flag(0);
        repeat (4) @(negedge mclk_in);
        chk({15'h0, busy_out}, 16'h0);
        $display("test refusal, abort and repeat done");
        @(negedge mclk_in) mode_in = SAS_MODE_ONESHOT;
        ext_trig_sel_in = 1;
        run1(4'h3, 1'b1);
        $display("test external retrigger done");
        summarize;
    end
endmodule : tb_top
